/* File: common/slrc_regs.svh */
// constants for the suspend, lock and reset sequencer
`ifndef SLRC_REGS_SVH
`define SLRC_REGS_SVH

// avalon register byte offsets
`define SLRC_CTRL_OFS            4'h0
`define SLRC_STATUS_OFS          4'h4
`define SLRC_FAIL_CLR_OFS        4'h8
`define SLRC_CTRL_RESET          8'h00

// control register fields
`define SLRC_CTRL_PSEL_BIT       0
`define SLRC_CTRL_BPROT_LSB      1
`define SLRC_CTRL_COMPL_BIT      6
`define SLRC_CTRL_QPI_BIT        7

// serial command codes
`define SLRC_WRITE_ENABLE_CMD    8'h06
`define SLRC_WRITE_DISABLE_CMD   8'h04
`define SLRC_STATUS_LOW_CMD      8'h05
`define SLRC_STATUS_HIGH_CMD     8'h35
`define SLRC_ELEC_ID_CMD         8'hab
`define SLRC_RESET_ARM_CMD       8'h66
`define SLRC_SOFT_RESET_CMD      8'h99
`define SLRC_NO_OP_CMD           8'h00
`define SLRC_SUSPEND_CMD         8'h75
`define SLRC_RESUME_CMD          8'h7a
`define SLRC_PAGE_PROG_CMD       8'h02
`define SLRC_SECTOR_ERASE_CMD    8'h20
`define SLRC_BLOCK_ERASE_CMD     8'hd8
`define SLRC_BLOCK_LOCK_CMD      8'h36
`define SLRC_BLOCK_UNLOCK_CMD    8'h39
`define SLRC_LOCK_STATUS_CMD     8'h3d
`define SLRC_GLOBAL_LOCK_CMD     8'h7e
`define SLRC_GLOBAL_UNLOCK_CMD   8'h98

// arbitrary electronic id value
`define SLRC_ELECTRONIC_ID       8'h5a

// timing, clock period and latencies in ns
`define SLRC_CLK_PERIOD_NS       20
`define SLRC_PROG_SUS_LAT_NS     30000
`define SLRC_ERASE_SUS_LAT_NS    30000
`define SLRC_PROG_TIME_NS        500000
`define SLRC_ERASE_TIME_NS       1000000
`define SLRC_PROG_SUS_LAT_CYC  ((`SLRC_PROG_SUS_LAT_NS + `SLRC_CLK_PERIOD_NS - 1) / `SLRC_CLK_PERIOD_NS)
`define SLRC_ERASE_SUS_LAT_CYC ((`SLRC_ERASE_SUS_LAT_NS + `SLRC_CLK_PERIOD_NS - 1) / `SLRC_CLK_PERIOD_NS)

`endif

/* File: common/slrc_pkg.sv */
// types for the suspend, lock and reset sequencer
package slrc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PROG,
    ST_ERASE,
    ST_SUSPENDING,
    ST_SUSPENDED,
    ST_SUS_PROG
  } slrc_op_t;

  typedef struct packed {
    logic       cs_n;
    logic       sclk;
    logic [3:0] sio;
  } slrc_pins_t;

  typedef struct packed {
    slrc_pins_t   sync1;
    slrc_pins_t   sync2;
    logic         sclk_d;
    logic         in_frame;
    logic [5:0]   bitcnt;
    logic [31:0]  shin;
    logic [7:0]   cmd;
    logic [23:0]  addr;
    logic         out_active;
    logic [2:0]   outcnt;
    logic [7:0]   shout;
    logic [3:0]   sio_out;
    logic [3:0]   sio_oe;
    logic         rst_armed;
    logic         write_enable_latch;
    logic         suspend_status_flag;
    logic         fail_flag;
    slrc_op_t     op;
    slrc_op_t     resume_op;
    logic         erase_sus;
    logic         erase_block64;
    logic [6:0]   erase_sector;
    logic [23:0]  timer;
    logic [23:0]  saved_timer;
    logic [127:0] lock;
    logic [7:0]   ctrl;
    logic         bus_done;
    logic [31:0]  readdata;
  } slrc_state_t;

endpackage : slrc_pkg

/* File: verilog/slrc_top.sv */
// serial flash suspend, block lock and software reset sequencer
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/10ps
`include "slrc_regs.svh"

module slrc_top #(
  parameter int unsigned PROG_CYCLES  = `SLRC_PROG_TIME_NS / `SLRC_CLK_PERIOD_NS,
  parameter int unsigned ERASE_CYCLES = `SLRC_ERASE_TIME_NS / `SLRC_CLK_PERIOD_NS
) (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire slrc_pkg::slrc_pins_t pins_in,
  output logic [3:0]             sio_out,
  output logic [3:0]             sio_oe,
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest
);
  import slrc_pkg::*;

  slrc_state_t s;
  slrc_state_t next_s;

  logic       write_in_progress;
  logic       qpi;
  logic       rise;
  logic       fall;
  logic       frame_end;
  logic       arm_now;
  logic       load_lock;
  logic [5:0] next_cnt;
  logic [31:0] next_shin;

  // protection of one 4kb sector, by lock bit or by bp/complement
  function automatic logic sect_prot(input logic [6:0] sec, input logic [127:0] lk,
                                     input logic [7:0] c);
    logic [4:0] lvl;
    logic [3:0] n;
    logic       hit;
    lvl = c[`SLRC_CTRL_BPROT_LSB +: 5];
    n   = (lvl == 5'h00) ? 4'h0 : (lvl >= 5'h04) ? 4'h8 : 4'(4'h1 << (lvl - 5'h01));
    hit = (4'h8 - n) <= {1'b0, sec[6:4]};
    if (c[`SLRC_CTRL_PSEL_BIT]) begin
      sect_prot = lk[sec];
    end else begin
      sect_prot = hit ^ c[`SLRC_CTRL_COMPL_BIT];
    end
  endfunction : sect_prot

  // byte served on the data lines for the current read command
  function automatic logic [7:0] rd_byte(input slrc_state_t st, input logic busy);
    case (st.cmd)
      `SLRC_STATUS_LOW_CMD:  rd_byte = {1'b0, st.ctrl[`SLRC_CTRL_BPROT_LSB +: 5], st.write_enable_latch, busy};
      `SLRC_STATUS_HIGH_CMD: rd_byte = {st.suspend_status_flag, st.ctrl[`SLRC_CTRL_COMPL_BIT], 6'h00};
      `SLRC_ELEC_ID_CMD:     rd_byte = `SLRC_ELECTRONIC_ID;
      `SLRC_LOCK_STATUS_CMD: rd_byte = {7'h00, st.lock[st.addr[18:12]]};
      default:               rd_byte = 8'h00;
    endcase
  endfunction : rd_byte

  assign write_in_progress  = (s.op != ST_IDLE) && (s.op != ST_SUSPENDED);
  assign qpi  = s.ctrl[`SLRC_CTRL_QPI_BIT];
  assign rise = s.in_frame && s.sync2.sclk && !s.sclk_d;
  assign fall = s.in_frame && !s.sync2.sclk && s.sclk_d;
  assign frame_end = s.in_frame && s.sync2.cs_n;
  assign arm_now = frame_end && (s.bitcnt == 6'd8) && (s.shin[7:0] == `SLRC_RESET_ARM_CMD);
  assign load_lock = rise && (next_cnt == 6'd32)
                     && (s.cmd == `SLRC_LOCK_STATUS_CMD);

  // shift-in datapath, one bit per edge single-wire, four bits in quad mode
  always_comb begin
    next_cnt  = (s.bitcnt > 6'd58) ? 6'd63 : 6'(s.bitcnt + (qpi ? 6'd4 : 6'd1));
    next_shin = qpi ? {s.shin[27:0], s.sync2.sio} : {s.shin[30:0], s.sync2.sio[0]};
  end

  // avalon slave handshake, one wait cycle then answer
  assign avs_waitrequest = (avs_read || avs_write) && !s.bus_done;
  assign avs_readdata    = s.readdata;
  assign sio_out         = s.sio_out;
  assign sio_oe          = s.sio_oe;

  // next state of the whole block
  always_comb begin
    logic        len8;
    logic        len32;
    logic [7:0]  c;
    logic [23:0] a;
    logic        anytime;
    logic        allowed;
    logic        fail_set;
    logic        in_erased;
    logic        prot;
    logic        sector_gran;
    logic        do_reset;
    next_s      = s;
    len8        = 1'b0;
    len32       = 1'b0;
    c           = 8'h00;
    a           = 24'h000000;
    anytime     = 1'b0;
    allowed     = 1'b0;
    fail_set    = 1'b0;
    in_erased   = 1'b0;
    prot        = 1'b0;
    sector_gran = 1'b0;
    do_reset    = 1'b0;

    // two-stage pin synchronisers
    next_s.sync1  = pins_in;
    next_s.sync2  = s.sync1;
    next_s.sclk_d = s.sync2.sclk;

    // frame start
    if (!s.in_frame && !s.sync2.cs_n) begin
      next_s.in_frame   = 1'b1;
      next_s.bitcnt     = 6'd0;
      next_s.out_active = 1'b0;
    end

    // command and address capture, read data start
    if (rise) begin
      next_s.bitcnt = next_cnt;
      next_s.shin   = next_shin;
      if (next_cnt == 6'd8) begin
        next_s.cmd = next_shin[7:0];
        if (next_shin[7:0] == `SLRC_STATUS_LOW_CMD || next_shin[7:0] == `SLRC_STATUS_HIGH_CMD) begin
          next_s.cmd        = next_shin[7:0];
          next_s.out_active = 1'b1;
          next_s.outcnt     = 3'd0;
          next_s.shout      = rd_byte(next_s, write_in_progress);
        end
      end
      if (next_cnt == 6'd32 && (s.cmd == `SLRC_ELEC_ID_CMD || s.cmd == `SLRC_LOCK_STATUS_CMD)) begin
        next_s.addr       = next_shin[23:0];
        next_s.out_active = 1'b1;
        next_s.outcnt     = 3'd0;
        next_s.shout      = rd_byte(next_s, write_in_progress);
      end
    end

    // shift-out on falling sclk, reload a freshly computed byte from the current state each time it empties
    if (fall && s.out_active) begin
      if (qpi) begin
        next_s.sio_out = s.shout[7:4];
        next_s.sio_oe  = 4'hf;
        next_s.shout   = {s.shout[3:0], 4'h0};
        next_s.outcnt  = 3'(s.outcnt + 3'd4);
      end else begin
        next_s.sio_out = {2'b00, s.shout[7], 1'b0};
        next_s.sio_oe  = 4'h2;
        next_s.shout   = {s.shout[6:0], 1'b0};
        next_s.outcnt  = 3'(s.outcnt + 3'd1);
      end
      if (next_s.outcnt == 3'd0) begin
        next_s.shout = rd_byte(s, write_in_progress);
      end
    end

    // operation timers
    if (s.op != ST_IDLE && s.op != ST_SUSPENDED) begin
      next_s.timer = (s.timer == 24'h000000) ? s.timer : 24'(s.timer - 24'h000001);
      if (s.timer == 24'h000000) begin
        unique case (s.op)
          ST_SUSPENDING: begin
            next_s.op  = ST_SUSPENDED;
            next_s.write_enable_latch = 1'b0;
            next_s.suspend_status_flag = 1'b1;
          end
          ST_SUS_PROG: begin
            next_s.op  = ST_SUSPENDED;
            next_s.write_enable_latch = 1'b0;
          end
          default: begin
            next_s.op  = ST_IDLE;
            next_s.write_enable_latch = 1'b0;
          end
        endcase
      end
    end

    // command execution when chip select rises
    if (frame_end) begin
      next_s.in_frame   = 1'b0;
      next_s.out_active = 1'b0;
      next_s.sio_oe     = 4'h0;
      len8  = (s.bitcnt == 6'd8);
      len32 = (s.bitcnt == 6'd32);
      c     = len32 ? s.shin[31:24] : s.shin[7:0];
      a     = s.shin[23:0];
      anytime = len8 && (c == `SLRC_WRITE_DISABLE_CMD || c == `SLRC_STATUS_LOW_CMD
                || c == `SLRC_STATUS_HIGH_CMD || c == `SLRC_ELEC_ID_CMD
                || c == `SLRC_RESET_ARM_CMD || c == `SLRC_SOFT_RESET_CMD
                || c == `SLRC_NO_OP_CMD);
      unique case (s.op)
        ST_IDLE:      allowed = 1'b1;
        ST_SUSPENDED: allowed = anytime || (s.suspend_status_flag && (c == `SLRC_RESUME_CMD
                      || c == `SLRC_LOCK_STATUS_CMD
                      || (s.erase_sus && (c == `SLRC_WRITE_ENABLE_CMD
                      || c == `SLRC_PAGE_PROG_CMD || c == `SLRC_BLOCK_UNLOCK_CMD
                      || c == `SLRC_GLOBAL_UNLOCK_CMD))));
        ST_PROG, ST_ERASE: allowed = anytime || c == `SLRC_SUSPEND_CMD;
        default:      allowed = anytime;
      endcase
      prot = sect_prot(a[18:12], s.lock, s.ctrl);
      in_erased = s.erase_block64 ? (a[18:16] == s.erase_sector[6:4])
                                  : (a[18:12] == s.erase_sector);
      sector_gran = (a[18:16] == 3'd0) || (a[18:16] == 3'd7);
      // any frame with at least one clocked bit, other than the arm itself, drops a pending arm
      if (s.bitcnt != 6'd0) begin
        next_s.rst_armed = 1'b0;
      end
      if (allowed && (len8 || len32 || c == `SLRC_PAGE_PROG_CMD)) begin
        case (c)
          `SLRC_RESET_ARM_CMD:     next_s.rst_armed = len8;
          `SLRC_SOFT_RESET_CMD:    do_reset = len8 && s.rst_armed;
          `SLRC_WRITE_ENABLE_CMD:  next_s.write_enable_latch = len8;
          `SLRC_WRITE_DISABLE_CMD: if (!write_in_progress) next_s.write_enable_latch = 1'b0;
          `SLRC_PAGE_PROG_CMD: begin
            // data bytes beyond the address are not modelled
            if (s.bitcnt >= 6'd32 && s.write_enable_latch && s.op != ST_SUSPENDED) begin
              if (prot) begin
                fail_set   = 1'b1;
                next_s.write_enable_latch = 1'b0;
              end else begin
                next_s.op    = ST_PROG;
                next_s.timer = 24'(PROG_CYCLES);
              end
            end else if (s.bitcnt >= 6'd32 && s.write_enable_latch && s.erase_sus) begin
              if (prot || in_erased) begin
                fail_set   = 1'b1;
                next_s.write_enable_latch = 1'b0;
              end else begin
                next_s.op    = ST_SUS_PROG;
                next_s.timer = 24'(PROG_CYCLES);
              end
            end
          end
          `SLRC_SECTOR_ERASE_CMD, `SLRC_BLOCK_ERASE_CMD: begin
            if (len32 && s.write_enable_latch) begin
              if (prot) begin
                fail_set   = 1'b1;
                next_s.write_enable_latch = 1'b0;
              end else begin
                next_s.op            = ST_ERASE;
                next_s.timer         = 24'(ERASE_CYCLES);
                next_s.erase_sector  = a[18:12];
                next_s.erase_block64 = (c == `SLRC_BLOCK_ERASE_CMD);
              end
            end
          end
          `SLRC_SUSPEND_CMD: begin
            if (len8) begin
              next_s.resume_op   = s.op;
              next_s.saved_timer = s.timer;
              next_s.erase_sus   = (s.op == ST_ERASE);
              next_s.op          = ST_SUSPENDING;
              next_s.timer       = (s.op == ST_ERASE) ? 24'(`SLRC_ERASE_SUS_LAT_CYC)
                                                      : 24'(`SLRC_PROG_SUS_LAT_CYC);
            end
          end
          `SLRC_RESUME_CMD: begin
            if (len8) begin
              next_s.op    = s.resume_op;
              next_s.timer = s.saved_timer;
              next_s.write_enable_latch   = 1'b1;
              next_s.suspend_status_flag   = 1'b0;
            end
          end
          `SLRC_BLOCK_LOCK_CMD, `SLRC_BLOCK_UNLOCK_CMD: begin
            if (len32 && s.write_enable_latch) begin
              for (int i = 0; i < 128; i++) begin
                if (sector_gran ? (7'(i) == a[18:12]) : (3'(i >> 4) == a[18:16])) begin
                  next_s.lock[i] = (c == `SLRC_BLOCK_LOCK_CMD);
                end
              end
              next_s.write_enable_latch = 1'b0;
            end
          end
          `SLRC_GLOBAL_LOCK_CMD, `SLRC_GLOBAL_UNLOCK_CMD: begin
            if (len8 && s.write_enable_latch) begin
              next_s.lock = (c == `SLRC_GLOBAL_LOCK_CMD) ? {128{1'b1}} : {128{1'b0}};
              next_s.write_enable_latch  = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end

    // software reset: standby, volatile defaults, failure flag kept
    if (do_reset) begin
      next_s.op        = ST_IDLE;
      next_s.write_enable_latch       = 1'b0;
      next_s.suspend_status_flag       = 1'b0;
      next_s.erase_sus = 1'b0;
      next_s.rst_armed = 1'b0;
      next_s.timer     = 24'h000000;
      next_s.lock      = {128{1'b1}};
    end

    // avalon register access, write lands at the edge that ends the wait
    next_s.bus_done = (avs_read || avs_write) && !s.bus_done;
    if (avs_read && !s.bus_done) begin
      unique case (avs_address)
        `SLRC_CTRL_OFS:   next_s.readdata = {24'h000000, s.ctrl};
        `SLRC_STATUS_OFS: next_s.readdata = {24'h000000, 3'(s.op), s.rst_armed, s.fail_flag,
                                             s.suspend_status_flag, s.write_enable_latch, write_in_progress};
        default:          next_s.readdata = 32'h00000000;
      endcase
    end
    if (avs_write && s.bus_done) begin
      if (avs_address == `SLRC_CTRL_OFS && avs_byteenable[0]) begin
        next_s.ctrl = avs_writedata[7:0];
      end
      if (avs_address == `SLRC_FAIL_CLR_OFS && avs_byteenable[0] && avs_writedata[0]) begin
        next_s.fail_flag = 1'b0;
      end
    end
    // a refusal in the clearing cycle still sets the flag
    if (fail_set) begin
      next_s.fail_flag = 1'b1;
    end
  end

  // all state in one register
  always_ff @(posedge mclk) begin
    if (reset) begin
      s          <= '0;
      s.sync1    <= '{cs_n: 1'b1, sclk: 1'b0, sio: 4'h0};
      s.sync2    <= '{cs_n: 1'b1, sclk: 1'b0, sio: 4'h0};
      s.op       <= ST_IDLE;
      s.resume_op <= ST_IDLE;
      s.ctrl     <= `SLRC_CTRL_RESET;
      s.lock     <= {128{1'b1}};
    end else begin
      s <= next_s;
    end
  end

  // suspend flag only rises as the suspend latency runs out
  a_sus_flag_rise: assert property (@(posedge mclk) disable iff (reset)
    $rose(s.suspend_status_flag) |-> ($past(s.op) == ST_SUSPENDING) && (s.op == ST_SUSPENDED) && !s.write_enable_latch)
    else $error("suspend flag set outside the end of latency");

  // resume sets latch and busy in the same edge that drops the flag
  a_resume_sets_bits: assert property (@(posedge mclk) disable iff (reset)
    ($fell(s.suspend_status_flag) && !$past(reset) && $past(s.op) == ST_SUSPENDED && s.op != ST_IDLE)
      |-> s.write_enable_latch && write_in_progress)
    else $error("resume did not set latch and busy");

  // program inside erase suspend keeps latch and busy high
  a_sus_prog_busy: assert property (@(posedge mclk) disable iff (reset)
    (s.op == ST_SUS_PROG) |-> s.write_enable_latch && write_in_progress && s.suspend_status_flag)
    else $error("program in suspend lost latch or busy");

  // on completion both bits drop together
  a_sus_prog_done: assert property (@(posedge mclk) disable iff (reset)
    ($past(s.op) == ST_SUS_PROG && s.op == ST_SUSPENDED) |-> !s.write_enable_latch && !write_in_progress)
    else $error("program in suspend ended with latch or busy set");

  // the program inside a suspend is neither suspended nor bypassed by resume
  a_no_nested_sus: assert property (@(posedge mclk) disable iff (reset)
    (s.op == ST_SUS_PROG) |=> (s.op != ST_SUSPENDING) && (s.op != ST_ERASE))
    else $error("erase resumed or suspend taken during program in suspend");

  // program during suspend only when the suspended operation is an erase
  a_prog_erase_only: assert property (@(posedge mclk) disable iff (reset)
    ($past(s.op) == ST_SUSPENDED && s.op == ST_SUS_PROG) |-> s.erase_sus && s.resume_op == ST_ERASE)
    else $error("program started inside a program suspend");

  // lock bits all set after reset release
  a_lock_after_reset: assert property (@(posedge mclk)
    $past(reset) && !reset |-> &s.lock)
    else $error("lock bits not all set after reset");

  // any frame with at least one clocked bit, other than the arm, leaves the arm cleared
  a_arm_cancel: assert property (@(posedge mclk) disable iff (reset)
    (frame_end && !arm_now && s.bitcnt != 6'd0) |=> !s.rst_armed)
    else $error("reset arm survived another command");

  // lock status byte carries only bit 0
  a_lock_byte: assert property (@(posedge mclk) disable iff (reset)
    load_lock |=> (s.shout[7:1] == 7'h00) && (s.shout[0] == s.lock[s.addr[18:12]]))
    else $error("lock status byte malformed");

endmodule : slrc_top

/* File: bench/slrc_host.sv */
// host serial bus controller model driving the flash pins
`timescale 1ns/10ps
module slrc_host (
  input  wire logic            mclk,
  input  wire logic [3:0]      sio_out,
  output slrc_pkg::slrc_pins_t pins
);
  import slrc_pkg::*;
  initial pins = '{cs_n: 1'b1, sclk: 1'b0, sio: 4'h0};
  // n clocks out msb first, then rb clocks read back on sio_out[1]
  task automatic frame(input logic [31:0] d, input int n, input int rb,
                       input bit q, output logic [7:0] rd);
    int i;
    rd = 8'h00;
    @(posedge mclk);
    pins.cs_n <= 1'b0;
    for (i = 0; i < n + rb; i++) begin
      // upper lines toggle in single-wire mode, they must not matter
      if (i < n) pins.sio <= q ? d[31-4*i -: 4] : {i[0], ~i[0], i[0], d[31-i]};
      repeat (4) @(posedge mclk);
      pins.sclk <= 1'b1;
      repeat (4) @(posedge mclk);
      if (i >= n) rd = {rd[6:0], sio_out[1]};
      pins.sclk <= 1'b0;
    end
    repeat (4) @(posedge mclk);
    pins.cs_n <= 1'b1;
    pins.sio  <= ~pins.sio; // released lines must not keep the last value
    repeat (8) @(posedge mclk);
  endtask : frame
endmodule : slrc_host

/* File: bench/tb_slrc_top.sv */
// self-checking bench for the suspend, lock and reset sequencer
`timescale 1ns/10ps
module tb_slrc_top;
  import slrc_pkg::*;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  slrc_pins_t  pins_in;
  logic [3:0]  sio_out, sio_oe;
  logic [3:0]  avs_address = 4'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic        avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic [7:0]  lfsr = 8'h51, rd;
  int          mismatches = 0;
  int          compares = 0;
  int          mlock [int]; // model lock bit per 64KB block
  int          mdef = 1;    // model value of unlisted blocks
  slrc_top #(.PROG_CYCLES(400), .ERASE_CYCLES(4000)) i_dut (.mclk, .reset, .pins_in,
    .sio_out, .sio_oe, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest);
  slrc_host i_host (.mclk, .sio_out, .pins(pins_in));
  always #10 mclk = ~mclk;
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // avalon access, request held until waitrequest is sampled low
  task automatic bus(input bit wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) mismatches++;
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic sf(input logic [7:0] c, input logic [23:0] a, input int n,
                    input int rb = 0, input bit qd = 1'b0);
    i_host.frame({c, a}, n, rb, qd, rd);
  endtask : sf
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nxt
  task automatic ck_lock(input logic [23:0] a);
    int e;
    e = mlock.exists(a[23:16]) ? mlock[a[23:16]] : mdef;
    sf(8'h3d, a, 32, 8);
    check(rd, {7'h0, e[0]});
  endtask : ck_lock
  // bound on the whole run
  initial begin
    #1000000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    logic [23:0] a;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    bus(0, 4'h4, 0);
    check(q, 32'h0);
    bus(1, 4'hc, 32'hff);
    bus(0, 4'h0, 0);
    check(q, 32'h0);
    a = {8'h01 + 8'(lfsr % 6), lfsr, nxt(lfsr)};
    lfsr = nxt(nxt(lfsr));
    ck_lock(a);
    sf(8'h39, a, 32);
    ck_lock(a);
    sf(8'h06, 0, 8);
    sf(8'h39, a, 32);
    mlock[a[23:16]] = 0;
    ck_lock(a);
    sf(8'h06, 0, 8);
    sf(8'h36, a, 31);
    ck_lock(a);
    sf(8'h06, 0, 8);
    sf(8'h36, a, 32);
    mlock[a[23:16]] = 1;
    ck_lock(a);
    $display("test lock bits done");
    bus(1, 4'h0, 32'h80);
    bus(0, 4'h0, 0);
    check(q, 32'h80);
    sf(8'h06, 0, 2, 0, 1'b1);
    sf(8'h98, 0, 2, 0, 1'b1);
    bus(1, 4'h0, 0);
    mlock.delete();
    mdef = 0;
    ck_lock(a);
    ck_lock(24'h000000);
    sf(8'h06, 0, 8);
    sf(8'h7e, 0, 8);
    mdef = 1;
    ck_lock(a);
    sf(8'h06, 0, 8);
    sf(8'h98, 0, 8);
    mdef = 0;
    $display("test global lock done");
    sf(8'h66, 0, 8);
    bus(0, 4'h4, 0);
    check(q, 32'h10);
    sf(8'h00, 0, 8);
    bus(0, 4'h4, 0);
    check(q, 32'h0);
    sf(8'h99, 0, 8);
    ck_lock(a);
    sf(8'h66, 0, 8);
    sf(8'h99, 0, 8);
    mdef = 1;
    ck_lock(a);
    $display("test soft reset done");
    sf(8'h06, 0, 8);
    sf(8'h20, 24'h010000, 32);
    sf(8'h75, 0, 8);
    sf(8'h35, 0, 8, 8);
    check(rd, 8'h00);
    repeat (1600) @(posedge mclk);
    sf(8'h35, 0, 8, 8);
    check(rd, 8'h80);
    sf(8'h05, 0, 8, 8);
    check(rd, 8'h00);
    sf(8'h06, 0, 8);
    sf(8'h02, 24'h030000, 32);
    sf(8'h05, 0, 8, 8);
    check(rd, 8'h03);
    sf(8'h75, 0, 8);
    bus(0, 4'h4, 0);
    check(q[7:5], 3'(ST_SUS_PROG));
    repeat (250) @(posedge mclk);
    sf(8'h05, 0, 8, 8);
    check(rd, 8'h00);
    sf(8'h35, 0, 8, 8);
    check(rd, 8'h80);
    sf(8'h06, 0, 8);
    sf(8'h02, 24'h010100, 32);
    sf(8'h05, 0, 8, 8);
    check(rd, 8'h00);
    sf(8'h7a, 0, 8);
    sf(8'h05, 0, 8, 8);
    check(rd, 8'h03);
    sf(8'h35, 0, 8, 8);
    check(rd, 8'h00);
    repeat (100) @(posedge mclk);
    sf(8'h75, 0, 8);
    repeat (1600) @(posedge mclk);
    sf(8'h35, 0, 8, 8);
    check(rd, 8'h80);
    $display("test suspend done");
    sf(8'h66, 0, 8);
    sf(8'h99, 0, 8);
    sf(8'h05, 0, 8, 8);
    check(rd, 8'h00);
    bus(0, 4'h4, 0);
    check(q, 32'h8);
    $display("test reset abort done");
    report_and_stop();
  end
endmodule : tb_slrc_top
